// [hw/mabx_exec.sv]
/*
  Execution core: fetch, decode and execute of the arithmetic, branch,
  bit, control and jump instructions, with fixed cycle counts per opcode.
  Assumes program and data memory answer combinationally within the cycle
  in which the address is presented.
*/
// Operation
// - Add, and, compare, subtract use accumulator plus memory or immediate byte.
// - Clear, decrement, increment reach any of the 256 data space bytes.
// - Complement, rotate and shift act only on the accumulator.
// - Complement is one byte, four cycles, updates Z and C.
// - Rotate is one byte, shift two bytes, four cycles, Z and C.
// - Short branch reaches -15 to +16 around the branch.
// - Bit-test branches jump on bit clear or set; 3 bytes, 5 cycles.
// - Bit-test displacement is signed 8-bit reaching -126 to +129.
// - Bit-test copies the tested bit into carry, keeps zero.
// - Bit set and clear pick a bit by 3 opcode bits; 2 bytes, 4 cycles.
// - Bit set and clear reach any bit of any data space byte.
// - No-operation and return are one byte, two cycles, flags kept.
// - Interrupt return is one byte, two cycles, restores Z and C.
// - Stop and wait are one byte, two cycles, flags kept.
// - Jump and call use a 12-bit target over the program space.
// - With watchdog selected, stop behaves as wait.
// - Jump and call are two bytes, four cycles, flags kept.
// - Short branch: one direction bit, four span bits.
`timescale 1ns/100ps
module mabx_exec (
  input  wire logic                        REF_CLK,
  input  wire logic                        RST,
  output logic [mabx_pkg::PC_W-1:0]        PM_ADDR,
  input  wire logic [mabx_pkg::DATA_W-1:0] PM_RDATA,
  output logic [mabx_pkg::DATA_W-1:0]      DM_ADDR,
  output logic [mabx_pkg::DATA_W-1:0]      DM_WDATA,
  output logic                             DM_WE,
  input  wire logic [mabx_pkg::DATA_W-1:0] DM_RDATA,
  input  wire logic                        IRQ,
  input  wire logic                        WDOG_SEL,
  output logic                             FETCH,
  output logic                             FLAG_Z,
  output logic                             FLAG_C,
  output logic [mabx_pkg::DATA_W-1:0]      ACC,
  output logic                             STOP_MODE,
  output logic                             WAIT_MODE
);
  import mabx_pkg::*;

  mabx_state_e state_r;
  mabx_alu_e   alu_op;
  logic [2:0]  cnt_r, sp_r, sp_top;
  logic [7:0]  op_r, b1_r, b2_r, ea_r, res_r, acc_r, dm_wdata_r;
  logic [7:0]  sreg_r [0:3];
  logic [11:0] stack_r [0:STACK_DEPTH-1];
  logic [11:0] pc_r, pm_addr_r, next_pc;
  logic        zn_r, cn_r, bitv_r, z_r, c_r, zs_r, cs_r, in_int_r, dm_we_r, fetch_r, stop_r, wait_r;
  logic [2:0]  grp;
  logic [1:0]  pin_raw, pin_lvl;
  logic [7:0]  ds_val, alu_a, alu_b, alu_res, bit_mask, bit_mod;
  logic        alu_z, alu_c, bitv, upd_z, upd_c, wr_acc, wr_ea, ea_int;
  logic        take_int, start, last, is_call, is_ret, is_interrupt_return, is_halt, is_stop, enter_halt, sbr_ok;

  // External pins pass three flops; a level is taken once the last two agree.
  assign pin_raw = {WDOG_SEL, IRQ};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1_r, s2_r, s3_r, lvl_r;
    always_ff @(posedge REF_CLK) begin
      if (RST) begin
        s1_r  <= 1'b0;
        s2_r  <= 1'b0;
        s3_r  <= 1'b0;
        lvl_r <= 1'b0;
      end else begin
        s1_r <= pin_raw[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) lvl_r <= s3_r;
      end
    end
    assign pin_lvl[i] = lvl_r;
  end

  // Sequencing terms; the opcode is only valid in op_r from cycle 1 on.
  assign grp      = op_r[7:5];
  assign take_int = pin_lvl[0] && !in_int_r && cnt_r == 3'h0;
  assign start    = state_r == ST_RUN && cnt_r == 3'h0 && !take_int;
  assign last     = state_r == ST_RUN && cnt_r != 3'h0 && cnt_r == instr_cyc(op_r) - 3'h1;
  assign is_call  = grp == GRP_JP && op_r[4];
  assign is_ret   = grp == GRP_MISC && op_r[4:3] == MSUB_ACC && (op_r[2:0] == MS_RET || op_r[2:0] == MS_INTERRUPT_RETURN);
  assign is_interrupt_return  = is_ret && op_r[0] == 1'b0;
  assign is_stop  = grp == GRP_MISC && op_r[4:3] == MSUB_ACC && op_r[2:0] == MS_STOP;
  assign is_halt  = is_stop || (grp == GRP_MISC && op_r[4:3] == MSUB_WAIT);
  assign enter_halt = last && is_halt;
  assign sp_top   = (sp_r == 3'h0) ? 3'h0 : sp_r - 3'h1;

  // Operand read: accumulator and short registers live here, the rest outside.
  assign ea_int = ea_r == ADDR_ACC || ea_r[7:2] == ADDR_SREG[7:2];
  assign ds_val = (ea_r == ADDR_ACC) ? acc_r : (ea_r[7:2] == ADDR_SREG[7:2]) ? sreg_r[ea_r[1:0]] : DM_RDATA;

  // Bit selection comes straight from three opcode bits.
  assign bit_mask = 8'h01 << op_r[2:0];
  assign bitv     = |(ds_val & bit_mask);
  assign bit_mod  = op_r[3] ? (ds_val | bit_mask) : (ds_val & ~bit_mask);

  // Decode of operand sources, flag effects and destination.
  always_comb begin
    alu_op = AO_ZERO;
    alu_a  = acc_r;
    alu_b  = ds_val;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    wr_acc = 1'b0;
    wr_ea  = 1'b0;
    case (grp)
      GRP_ALU: begin
        if (!op_r[4]) begin
          alu_b  = (op_r[1:0] == MD_IMM) ? b1_r : ds_val;
          upd_z  = 1'b1;
          upd_c  = 1'b1;
          wr_acc = op_r[4:2] != ALU_CP;
          case (op_r[4:2])
            ALU_ADD: alu_op = AO_ADD;
            ALU_AND: alu_op = AO_AND;
            default: alu_op = AO_SUB;
          endcase
        end else if (op_r[4:2] == ALU_CLR) begin
          wr_ea = 1'b1;
        end else if (op_r[4:2] != 3'h7) begin
          alu_a  = ds_val;
          alu_op = op_r[2] ? AO_DEC : AO_INC;
          upd_z  = 1'b1;
          wr_ea  = 1'b1;
        end
      end
      GRP_MISC: begin
        case (op_r[4:3])
          MSUB_INC, MSUB_DEC: begin
            alu_a  = ds_val;
            alu_op = op_r[3] ? AO_DEC : AO_INC;
            upd_z  = 1'b1;
            wr_ea  = 1'b1;
          end
          MSUB_ACC: begin
            if (!op_r[2]) begin
              upd_z  = 1'b1;
              upd_c  = 1'b1;
              wr_acc = 1'b1;
              case (op_r[2:0])
                MS_COM:  alu_op = AO_COM;
                MS_RLC:  alu_op = AO_RLC;
                MS_SLA:  alu_op = AO_SLA;
                default: alu_op = AO_ZERO;
              endcase
            end
          end
          default: upd_z = 1'b0;
        endcase
      end
      GRP_BIT: wr_ea = !op_r[4];
      default: wr_ea = 1'b0;
    endcase
  end

  mabx_alu u_alu (
    .op  (alu_op),
    .a   (alu_a),
    .b   (alu_b),
    .cin (c_r),
    .res (alu_res),
    .zf  (alu_z),
    .cf  (alu_c)
  );

  // Short branch condition picked by the two low group bits.
  always_comb begin
    case (grp[1:0])
      2'h0:    sbr_ok = c_r;
      2'h1:    sbr_ok = !c_r;
      2'h2:    sbr_ok = z_r;
      default: sbr_ok = !z_r;
    endcase
  end

  // Address of the following instruction; a taken branch overrides it.
  always_comb begin
    next_pc = pc_r + {10'h000, instr_len(op_r)};
    if (grp < GRP_JP) begin
      if (sbr_ok) next_pc = op_r[4] ? pc_r - {8'h00, op_r[3:0]} : pc_r + {8'h00, op_r[3:0]} + 12'h001;
    end else if (grp == GRP_JP) begin
      next_pc = {op_r[3:0], b1_r};
    end else if (grp == GRP_BIT) begin
      if (op_r[4] && bitv_r == op_r[3]) next_pc = pc_r + 12'h002 + {{4{b2_r[7]}}, b2_r};
    end else if (is_ret) begin
      next_pc = stack_r[sp_top];
    end
  end

  // Run state and cycle counter; stop falls back to wait under the watchdog.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r <= ST_RUN;
      cnt_r   <= 3'h0;
      fetch_r <= 1'b1;
      stop_r  <= 1'b0;
      wait_r  <= 1'b0;
    end else begin
      fetch_r <= take_int || (last && !is_halt);
      case (state_r)
        ST_RUN: begin
          if (take_int) cnt_r <= 3'h0;
          else if (last) begin
            cnt_r <= 3'h0;
            if (enter_halt) begin
              state_r <= (is_stop && !pin_lvl[1]) ? ST_STOP : ST_WAIT;
              stop_r  <= is_stop && !pin_lvl[1];
              wait_r  <= !(is_stop && !pin_lvl[1]);
            end
          end else cnt_r <= cnt_r + 3'h1;
        end
        ST_WAIT, ST_STOP: begin
          if (take_int) begin
            state_r <= ST_RUN;
            stop_r  <= 1'b0;
            wait_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_RUN;
          stop_r  <= 1'b0;
          wait_r  <= 1'b0;
        end
      endcase
    end
  end

  // Program counter and fetch address; the latter walks the instruction bytes.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pc_r      <= RESET_PC;
      pm_addr_r <= RESET_PC;
    end else if (take_int) begin
      pc_r      <= INT_VEC;
      pm_addr_r <= INT_VEC;
    end else if (last) begin
      pc_r      <= next_pc;
      pm_addr_r <= next_pc;
    end else if (start) begin
      pm_addr_r <= pc_r + 12'h001;
    end else if (state_r == ST_RUN && cnt_r == 3'h1) begin
      pm_addr_r <= pc_r + 12'h002;
    end
  end

  // Opcode, operand bytes, effective address and staged results.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      op_r   <= 8'h00;
      b1_r   <= 8'h00;
      b2_r   <= 8'h00;
      ea_r   <= 8'h00;
      res_r  <= 8'h00;
      zn_r   <= 1'b0;
      cn_r   <= 1'b0;
      bitv_r <= 1'b0;
    end else if (state_r == ST_RUN) begin
      if (start) begin
        op_r <= PM_RDATA;
        if (PM_RDATA[7:5] == GRP_ALU && PM_RDATA[1:0] == MD_IX) ea_r <= sreg_r[0];
        if (PM_RDATA[7:5] == GRP_ALU && PM_RDATA[1:0] == MD_IY) ea_r <= sreg_r[1];
        if (PM_RDATA[7:5] == GRP_MISC && !PM_RDATA[4]) ea_r <= {ADDR_SREG[7:2], PM_RDATA[1:0]};
      end
      if (cnt_r == 3'h1) begin
        b1_r <= PM_RDATA;
        if (grp == GRP_BIT || (grp == GRP_ALU && (op_r[1] || op_r[4:2] == ALU_CLR))) ea_r <= PM_RDATA;
      end
      if (cnt_r == 3'h2) begin
        b2_r   <= PM_RDATA;
        res_r  <= (grp == GRP_BIT) ? bit_mod : alu_res;
        zn_r   <= alu_z;
        cn_r   <= alu_c;
        bitv_r <= bitv;
      end
    end
  end

  // Write strobe to external data memory in the last cycle of a write.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dm_we_r    <= 1'b0;
      dm_wdata_r <= 8'h00;
    end else begin
      dm_we_r <= state_r == ST_RUN && cnt_r == 3'h2 && wr_ea && !ea_int;
      if (state_r == ST_RUN && cnt_r == 3'h2) dm_wdata_r <= (grp == GRP_BIT) ? bit_mod : alu_res;
    end
  end

  // Accumulator and short registers are written at instruction end.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_r <= 8'h00;
      for (int k = 0; k < 4; k++) sreg_r[k] <= 8'h00;
    end else if (last) begin
      if (wr_acc || (wr_ea && ea_r == ADDR_ACC)) acc_r <= res_r;
      else if (wr_ea && ea_r[7:2] == ADDR_SREG[7:2]) sreg_r[ea_r[1:0]] <= res_r;
    end
  end

  // Flags change only where the instruction marks them; all else holds.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      z_r <= 1'b0;
      c_r <= 1'b0;
    end else if (last) begin
      if (is_interrupt_return) begin
        z_r <= zs_r;
        c_r <= cs_r;
      end else if (grp == GRP_BIT && op_r[4]) begin
        c_r <= bitv_r;
      end else begin
        if (upd_z) z_r <= zn_r;
        if (upd_c) c_r <= cn_r;
      end
    end
  end

  // Return stack; a push when full overwrites the top entry rather than wrap.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sp_r     <= 3'h0;
      in_int_r <= 1'b0;
      zs_r     <= 1'b0;
      cs_r     <= 1'b0;
      for (int k = 0; k < STACK_DEPTH; k++) stack_r[k] <= 12'h000;
    end else if (take_int) begin
      in_int_r <= 1'b1;
      zs_r     <= z_r;
      cs_r     <= c_r;
      if (sp_r < STACK_FULL) stack_r[sp_r] <= pc_r;
      else stack_r[STACK_DEPTH-1] <= pc_r;
      if (sp_r < STACK_FULL) sp_r <= sp_r + 3'h1;
    end else if (last && is_call) begin
      if (sp_r < STACK_FULL) stack_r[sp_r] <= pc_r + 12'h002;
      else stack_r[STACK_DEPTH-1] <= pc_r + 12'h002;
      if (sp_r < STACK_FULL) sp_r <= sp_r + 3'h1;
    end else if (last && is_ret) begin
      sp_r <= sp_top;
      if (is_interrupt_return) in_int_r <= 1'b0;
    end
  end

  assign PM_ADDR   = pm_addr_r;
  assign DM_ADDR   = ea_r;
  assign DM_WDATA  = dm_wdata_r;
  assign DM_WE     = dm_we_r;
  assign FETCH     = fetch_r;
  assign FLAG_Z    = z_r;
  assign FLAG_C    = c_r;
  assign ACC       = acc_r;
  assign STOP_MODE = stop_r;
  assign WAIT_MODE = wait_r;

  AST_SBR_TWO_CYCLES: assert property (
    @(posedge REF_CLK) disable iff (RST) start && PM_RDATA[7:5] < GRP_JP |=> cnt_r == 3'h1 ##1 cnt_r == 3'h0)
    else $error("Short branch did not take two cycles.");
  AST_SBR_FLAGS_KEPT: assert property (
    @(posedge REF_CLK) disable iff (RST) start && PM_RDATA[7:5] < GRP_JP |-> ##2 $stable(z_r) && $stable(c_r))
    else $error("Short branch altered a flag.");
  AST_BTB_FIVE_CYCLES: assert property (
    @(posedge REF_CLK) disable iff (RST) start && PM_RDATA[7:4] == {GRP_BIT, 1'b1} |-> ##4 last ##1 cnt_r == 3'h0)
    else $error("Bit-test branch did not take five cycles.");
  AST_BTB_CARRY: assert property (
    @(posedge REF_CLK) disable iff (RST) last && grp == GRP_BIT && op_r[4] |=> c_r == $past(bitv_r) && $stable(z_r))
    else $error("Bit-test branch did not copy the bit into carry.");
  AST_ALU_FOUR_CYCLES: assert property (
    @(posedge REF_CLK) disable iff (RST) start && PM_RDATA[7:5] == GRP_ALU |-> ##3 last ##1 cnt_r == 3'h0)
    else $error("Arithmetic instruction did not take four cycles.");
  AST_INCDEC_KEEP_C: assert property (
    @(posedge REF_CLK) disable iff (RST) last && grp == GRP_MISC && !op_r[4] |=> $stable(c_r))
    else $error("Increment or decrement changed carry.");
  AST_CLR_R_NO_FLAGS: assert property (
    @(posedge REF_CLK) disable iff (RST) last && grp == GRP_ALU && op_r[4:2] == ALU_CLR |=> $stable({z_r, c_r}))
    else $error("Clear of a data register changed a flag.");
  AST_SBR_FWD_TARGET: assert property (
    @(posedge REF_CLK) disable iff (RST) last && grp < GRP_JP && sbr_ok && !op_r[4]
      |=> pc_r == $past(pc_r) + {8'h00, $past(op_r[3:0])} + 12'h001)
    else $error("Forward short branch went to the wrong address.");
  AST_JP_TARGET: assert property (
    @(posedge REF_CLK) disable iff (RST) last && grp == GRP_JP |=> pc_r == {$past(op_r[3:0]), $past(b1_r)})
    else $error("Jump or call went to the wrong address.");
  AST_STOP_AS_WAIT: assert property (
    @(posedge REF_CLK) disable iff (RST) last && is_stop && pin_lvl[1] |=> WAIT_MODE && !STOP_MODE)
    else $error("Stop was not turned into wait under the watchdog.");
  AST_BIT_WRITE: assert property (
    @(posedge REF_CLK) disable iff (RST) DM_WE && grp == GRP_BIT |-> DM_WDATA[op_r[2:0]] == op_r[3] && last)
    else $error("Bit set or clear wrote the wrong bit value.");

endmodule

// [hw/mabx_pkg.sv]
/*
  Shared constants, types and decode functions for the execution core:
  opcode fields, data space locations, stack depth and the per-opcode
  byte and cycle figures.
  Assumes a single core clock and that the core and ALU files import this package.
*/
package mabx_pkg;

  localparam int PC_W        = 12;
  localparam int DATA_W      = 8;
  localparam int STACK_DEPTH = 6;
  localparam logic [2:0] STACK_FULL = 3'h6;

  // Data space locations held inside the core.
  localparam logic [7:0] ADDR_SREG = 8'h80;  // X, Y, V, W at 80h to 83h.
  localparam logic [7:0] ADDR_ACC  = 8'hFF;

  // Program counter after reset and on interrupt entry.
  localparam logic [11:0] RESET_PC = 12'h000;
  localparam logic [11:0] INT_VEC  = 12'h004;

  // Opcode groups in bits 7 to 5; groups 0 to 3 are short branches.
  localparam logic [2:0] GRP_JP   = 3'h4;
  localparam logic [2:0] GRP_BIT  = 3'h5;
  localparam logic [2:0] GRP_ALU  = 3'h6;
  localparam logic [2:0] GRP_MISC = 3'h7;

  // Arithmetic group: operation in bits 4 to 2, mode in bits 1 to 0.
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_AND = 3'h1;
  localparam logic [2:0] ALU_CP  = 3'h2;
  localparam logic [2:0] ALU_CLR = 3'h6;
  localparam logic [1:0] MD_IX   = 2'h0;
  localparam logic [1:0] MD_IY   = 2'h1;
  localparam logic [1:0] MD_IMM  = 2'h3;

  // Miscellaneous group: subgroup in bits 4 to 3, code in bits 2 to 0.
  localparam logic [1:0] MSUB_INC  = 2'h0;
  localparam logic [1:0] MSUB_DEC  = 2'h1;
  localparam logic [1:0] MSUB_ACC  = 2'h2;
  localparam logic [1:0] MSUB_WAIT = 2'h3;
  localparam logic [2:0] MS_COM  = 3'h0;
  localparam logic [2:0] MS_RLC  = 3'h1;
  localparam logic [2:0] MS_SLA  = 3'h2;
  localparam logic [2:0] MS_CLRA = 3'h3;
  localparam logic [2:0] MS_NOP  = 3'h4;
  localparam logic [2:0] MS_RET  = 3'h5;
  localparam logic [2:0] MS_INTERRUPT_RETURN = 3'h6;
  localparam logic [2:0] MS_STOP = 3'h7;

  // Instruction cycle counts.
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_STD   = 3'h4;
  localparam logic [2:0] CYC_BTB   = 3'h5;

  typedef enum {ST_RUN, ST_WAIT, ST_STOP} mabx_state_e;
  typedef enum {AO_ADD, AO_AND, AO_SUB, AO_INC, AO_DEC, AO_COM, AO_RLC, AO_SLA, AO_ZERO} mabx_alu_e;

  // Length in bytes of the instruction that starts with this opcode.
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    instr_len = 2'h1;
    case (op[7:5])
      GRP_JP:   instr_len = 2'h2;
      GRP_BIT:  instr_len = op[4] ? 2'h3 : 2'h2;
      GRP_ALU: begin
        if (op[4:2] == ALU_CLR) instr_len = 2'h3;
        else if (op[1]) instr_len = 2'h2;
      end
      GRP_MISC: begin
        if (op[4:3] == MSUB_ACC && (op[2:0] == MS_SLA || op[2:0] == MS_CLRA)) instr_len = 2'h2;
      end
      default: instr_len = 2'h1;
    endcase
  endfunction

  // Number of core cycles the instruction occupies, opcode fetch included.
  function automatic logic [2:0] instr_cyc(input logic [7:0] op);
    instr_cyc = CYC_STD;
    case (op[7:5])
      GRP_JP:   instr_cyc = CYC_STD;
      GRP_BIT:  instr_cyc = op[4] ? CYC_BTB : CYC_STD;
      GRP_ALU:  instr_cyc = CYC_STD;
      GRP_MISC: begin
        if (op[4:3] == MSUB_WAIT || (op[4:3] == MSUB_ACC && op[2])) instr_cyc = CYC_SHORT;
      end
      default:  instr_cyc = CYC_SHORT;
    endcase
  endfunction

endpackage

// [hw/mabx_alu.sv]
/*
  Combinational arithmetic and logic unit of the execution core.
  Assumes the caller decides which flags are kept; carry in is passed
  through unchanged by increment and decrement.
*/
`timescale 1ns/100ps
module mabx_alu (
  input  mabx_pkg::mabx_alu_e op,
  input  logic [7:0]          a,
  input  logic [7:0]          b,
  input  logic                cin,
  output logic [7:0]          res,
  output logic                zf,
  output logic                cf
);
  import mabx_pkg::*;

  logic [8:0] sum;

  // Carry of subtract and compare is the borrow, set when b exceeds a.
  always_comb begin
    sum = {1'b0, a} + {1'b0, b};
    res = 8'h00;
    cf  = cin;
    case (op)
      AO_ADD: begin res = sum[7:0]; cf = sum[8]; end
      AO_AND: begin res = a & b; cf = 1'b0; end
      AO_SUB: begin res = a - b; cf = (a < b); end
      AO_INC: res = a + 8'h01;
      AO_DEC: res = a - 8'h01;
      AO_COM: begin res = ~a; cf = a[7]; end
      AO_RLC: begin res = {a[6:0], cin}; cf = a[7]; end
      AO_SLA: begin res = {a[6:0], 1'b0}; cf = a[7]; end
      default: begin res = 8'h00; cf = 1'b0; end
    endcase
    zf = (res == 8'h00);
  end

endmodule

// [dv/mabx_mem_model.sv]
/*
  Behavioural program and data memory seen by the execution core.
  Assumes the bench fills both arrays before reset is released.
*/
`timescale 1ns/100ps
module mabx_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] pm_addr,
  output logic      [7:0]  pm_rdata,
  input  wire logic [7:0]  dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  output logic      [7:0]  dm_rdata
);
  logic [7:0] pm [0:4095];
  logic [7:0] dm [0:255];
  // Reads answer in the same cycle, because the core samples the byte at the edge ending that cycle.
  assign pm_rdata = pm[pm_addr];
  assign dm_rdata = dm[dm_addr];
  // A write lands at the edge that ends the strobe cycle.
  always @(posedge clk) begin
    if (dm_we) begin
      dm[dm_addr] <= dm_wdata;
    end
  end
endmodule

// [dv/tb_top.sv]
/*
  Self-checking bench for the execution core: arithmetic, branches, bit ops, jump, stop and wait.
  Assumes the memory model answers combinationally; the interrupt pin is raised only by the interrupt scenario.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  logic        ref_clk, rst, irq, wdog_sel, dm_we, fetch, flag_z, flag_c, stop_mode, wait_mode;
  logic [11:0] pm_addr;
  logic [7:0]  pm_rdata, dm_addr, dm_wdata, dm_rdata, acc;
  int          num_errors, check_count, cyc;

  mabx_exec mabx_exec_i (.REF_CLK(ref_clk), .RST(rst), .PM_ADDR(pm_addr), .PM_RDATA(pm_rdata),
    .DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .DM_WE(dm_we), .DM_RDATA(dm_rdata), .IRQ(irq),
    .WDOG_SEL(wdog_sel), .FETCH(fetch), .FLAG_Z(flag_z), .FLAG_C(flag_c), .ACC(acc),
    .STOP_MODE(stop_mode), .WAIT_MODE(wait_mode));
  mabx_mem_model mabx_mem_model_i (.clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));

  // Free-running 50 ns core clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // A hang is cut short well above the hundred or so cycles the scenarios need.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic put(input logic [11:0] a, input logic [7:0] d);
    mabx_mem_model_i.pm[a] = d;
  endtask

  // Reset is released on a falling edge, so the step that follows is in cycle 0.
  task automatic do_reset;
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
  endtask

  // Counts the cycles until the next opcode fetch, then checks the count and the new address.
  task automatic step(input int exp_cyc, input logic [11:0] exp_pc);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (fetch !== 1'b1 && n < 20);
    `CHK("cycles", exp_cyc, n)
    `CHK("pc", exp_pc, pm_addr)
  endtask

  // Two immediate adds wrap the accumulator to zero, then a short increment and a complement.
  task automatic run_alu;
    put(12'h000, 8'hC3); put(12'h001, 8'h80); put(12'h002, 8'hC3); put(12'h003, 8'h80);
    put(12'h004, 8'hE0); put(12'h005, 8'hF0);
    do_reset();
    step(4, 12'h002);
    step(4, 12'h004);
    `CHK("zero", 1'b1, flag_z)
    `CHK("carry", 1'b1, flag_c)
    step(4, 12'h005);
    `CHK("carry", 1'b1, flag_c)
    `CHK("zero", 1'b0, flag_z)
    step(4, 12'h006);
    `CHK("acc", 8'hFF, acc)
    `CHK("carry", 1'b0, flag_c)
  endtask

  // Not taken on carry, taken forward on no carry, taken backward on nonzero.
  task automatic run_branch;
    put(12'h000, 8'h03); put(12'h001, 8'h24); put(12'h006, 8'h76);
    do_reset();
    step(2, 12'h001);
    step(2, 12'h006);
    step(2, 12'h000);
    `CHK("zero", 1'b0, flag_z)
  endtask

  // Bit set in external memory, a taken bit test on it, a long jump and a stop.
  task automatic run_bits;
    mabx_mem_model_i.dm[8'h10] = 8'h00;
    put(12'h000, 8'hAD); put(12'h001, 8'h10); put(12'h002, 8'hBD); put(12'h003, 8'h10);
    put(12'h004, 8'h08); put(12'h00C, 8'h81); put(12'h00D, 8'h23); put(12'h123, 8'hF7);
    do_reset();
    step(4, 12'h002);
    `CHK("dm", 8'h20, mabx_mem_model_i.dm[8'h10])
    step(5, 12'h00C);
    `CHK("carry", 1'b1, flag_c)
    `CHK("zero", 1'b0, flag_z)
    step(4, 12'h123);
    repeat (6) @(negedge ref_clk);
    `CHK("stop", 1'b1, stop_mode)
  endtask

  // With the watchdog option set, stop must fall back to wait.
  task automatic run_wdog;
    wdog_sel = 1'b1;
    put(12'h000, 8'hF4); put(12'h001, 8'hF4); put(12'h002, 8'hF4); put(12'h003, 8'hF7);
    do_reset();
    step(2, 12'h001);
    step(2, 12'h002);
    step(2, 12'h003);
    repeat (6) @(negedge ref_clk);
    `CHK("wait", 1'b1, wait_mode)
    `CHK("stop", 1'b0, stop_mode)
  endtask

  // Call, accumulator clear, complement, rotate, shift, direct decrement and clear, then return.
  task automatic run_misc;
    mabx_mem_model_i.dm[8'h20] = 8'h01;
    mabx_mem_model_i.dm[8'h21] = 8'h55;
    put(12'h000, 8'h90); put(12'h001, 8'h10); put(12'h010, 8'hF3); put(12'h012, 8'hF0);
    put(12'h013, 8'hF1); put(12'h014, 8'hF2); put(12'h016, 8'hD6); put(12'h017, 8'h20);
    put(12'h018, 8'hDA); put(12'h019, 8'h21); put(12'h01B, 8'hF5);
    do_reset();
    step(4, 12'h010);
    step(4, 12'h012);
    `CHK("zero", 1'b1, flag_z)
    `CHK("carry", 1'b0, flag_c)
    step(4, 12'h013);
    step(4, 12'h014);
    `CHK("acc", 8'hFE, acc)
    `CHK("carry", 1'b1, flag_c)
    step(4, 12'h016);
    `CHK("acc", 8'hFC, acc)
    step(4, 12'h018);
    `CHK("dm", 8'h00, mabx_mem_model_i.dm[8'h20])
    `CHK("zero", 1'b1, flag_z)
    `CHK("carry", 1'b1, flag_c)
    step(4, 12'h01B);
    `CHK("dm", 8'h00, mabx_mem_model_i.dm[8'h21])
    `CHK("carry", 1'b1, flag_c)
    step(2, 12'h002);
    `CHK("carry", 1'b1, flag_c)
  endtask

  // A wait is left by an interrupt whose handler changes both flags; the return restores them.
  task automatic run_irq;
    put(12'h000, 8'hF3); put(12'h001, 8'h00); put(12'h002, 8'hF8);
    put(12'h004, 8'hF0); put(12'h005, 8'hF1); put(12'h006, 8'hF6);
    do_reset();
    step(4, 12'h002);
    repeat (3) @(negedge ref_clk);
    `CHK("wait", 1'b1, wait_mode)
    irq = 1'b1;
    step(5, 12'h004);
    irq = 1'b0;
    step(4, 12'h005);
    step(4, 12'h006);
    `CHK("carry", 1'b1, flag_c)
    step(2, 12'h003);
    `CHK("zero", 1'b1, flag_z)
    `CHK("carry", 1'b0, flag_c)
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Memory is cleared before reset so no unknown opcode is ever fetched.
  initial begin
    rst = 1'b1;
    wdog_sel = 1'b0;
    irq = 1'b0;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    for (int i = 0; i < 4096; i++) put(i[11:0], 8'h00);
    for (int i = 0; i < 256; i++) mabx_mem_model_i.dm[i] = 8'h00;
    run_alu();
    run_branch();
    run_bits();
    run_wdog();
    run_misc();
    run_irq();
    summarize();
  end
endmodule
